// ### verilog/clock_select_pkg.sv
// Purpose: shared constants, encodings and carriers of the clock select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: printed offsets are register indices, byte address is four times
package clock_select_pkg;

   localparam int ADDR_W = 20;

   // register indices as printed; the word view index is placed after them
   localparam logic [ADDR_W-1:0] ZERO_INDEX = 20'h0F002;
   localparam logic [ADDR_W-1:0] ONE_INDEX = 20'h0F003;
   localparam logic [ADDR_W-1:0] FWORD_INDEX = 20'h0F004;
   localparam logic [ADDR_W-1:0] ZERO_ADDR = {ZERO_INDEX[ADDR_W-3:0], 2'h0};
   localparam logic [ADDR_W-1:0] ONE_ADDR = {ONE_INDEX[ADDR_W-3:0], 2'h0};
   localparam logic [ADDR_W-1:0] FWORD_ADDR = {FWORD_INDEX[ADDR_W-3:0], 2'h0};

   // reset values
   localparam logic [7:0] ZERO_RESET = 8'h33;
   localparam logic [7:0] ONE_RESET = 8'h03;

   // field positions of control register zero
   localparam int DIV_LSB = 0;
   localparam int MODE_LSB = 2;
   localparam int OUT_LSB = 4;

   // field positions of control register one
   localparam int SEL_BIT = 0;
   localparam int EN_BIT = 1;
   localparam int DBL_BIT = 2;
   localparam int LOCK_BIT = 7;

   // byte lane of the high register inside the word view
   localparam int HI_LANE = 1;

   typedef enum logic [1:0] {
      MODE_RC = 2'h0,
      MODE_XTAL = 2'h1,
      MODE_PLL = 2'h2,
      MODE_EXT = 2'h3
   } osc_mode_t;

   typedef enum logic [1:0] {
      DIV_1 = 2'h0,
      DIV_2 = 2'h1,
      DIV_4 = 2'h2,
      DIV_8 = 2'h3
   } div_code_t;

   // oscillator pulses counted before the oscillator clock is supplied
   localparam logic [12:0] RC_START_COUNT = 13'h0080;
   localparam logic [12:0] XTAL_START_COUNT = 13'h1000;
   localparam logic [12:0] PLL_START_COUNT = 13'h1000;
   localparam logic [12:0] EXT_START_COUNT = 13'h0001;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_COUNT,
      ST_RUN
   } start_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage

// ### verilog/osc_divider.sv
// Purpose: divides an oscillator pulse stream by 1, 2, 4 or 8
// Assumes: tick_in is a one-cycle strobe per oscillator period
// Notes: output pulse is registered, one cycle after the input pulse
`timescale 1ns/1ps
`default_nettype none
module osc_divider
   import clock_select_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick_in,
   input wire logic run,
   input wire div_code_t code,
   output logic tick_out
);

   logic [2:0] count;
   logic [2:0] next_count;
   logic next_tick_out;
   logic [2:0] mask;

   always_comb begin
      unique case (code)
         DIV_1: mask = 3'h0;
         DIV_2: mask = 3'h1;
         DIV_4: mask = 3'h3;
         DIV_8: mask = 3'h7;
      endcase
      next_count = count;
      next_tick_out = 1'b0;
      // a stopped source restarts the phase so the first period is whole
      if (!run) begin
         next_count = 3'h0;
      end else if (tick_in) begin
         next_count = count + 3'h1;
         next_tick_out = ((count & mask) == mask);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 3'h0;
         tick_out <= 1'b0;
      end else begin
         count <= next_count;
         tick_out <= next_tick_out;
      end
   end

endmodule
`default_nettype wire

// ### verilog/clock_select_and_divide.sv
// Purpose: frequency control registers and clock selection of the clock generator
// Assumes: oscillator and slow clocks arrive as one-cycle strobes on clk_sys
// Notes: APB slave answers one cycle after setup, no wait states
//
// Overview of operation
// R1 - after reset CPU runs on RC divided by eight
// R2 - fast divisor field picks 1, 1/2, 1/4, 1/8
// R3 - PLL mode turns undivided code into half
// R4 - mode field picks RC, crystal, PLL or external
// R5 - mode field writable only while oscillator disabled
// R6 - software drops to slow clock before mode change
// R7 - output divisor field picks 1, 1/2, 1/4, 1/8
// R8 - select bit routes slow or fast clock to CPU
// R9 - select bit forced zero while oscillator disabled
// R10 - enable bit starts and stops fast oscillator
// R11 - doubler bit gates the doubled slow clock
// R12 - lock flag reads one only when PLL in range
// R13 - register zero at its address, byte or word access
// R14 - register one at next address, byte only
// R15 - RC mode supplies clock after 128 pulses
// R16 - crystal mode supplies clock after 4096 pulses
// R17 - PLL mode supplies clock after 4096 pulses
// R18 - unused bits read zero and ignore writes
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_select_and_divide
   import clock_select_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   input wire logic osc_tick,
   input wire logic slow_tick,
   input wire logic slow_double_tick,
   input wire logic pll_in_range,
   output logic fast_osc_enable,
   output osc_mode_t osc_mode,
   output logic oscillator_clock_valid,
   output logic fast_clock_tick,
   output logic port_output_clock_tick,
   output logic cpu_clock_tick,
   output logic cpu_on_fast,
   output logic doubler_enable,
   output logic doubled_slow_clock_tick,
   output logic pll_lock_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_meta;
   logic rst_n;

   // async assert, release through two flops so no flop leaves reset alone
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register state

   div_code_t fast_div;
   div_code_t next_fast_div;
   div_code_t out_div;
   div_code_t next_out_div;
   osc_mode_t next_osc_mode;
   logic next_fast_osc_enable;
   logic next_cpu_on_fast;
   logic next_doubler_enable;
   logic next_pll_lock_flag;

   logic [7:0] zero_view;
   logic [7:0] one_view;

   always_comb begin
      zero_view = 8'h00;
      zero_view[DIV_LSB +: 2] = fast_div;
      zero_view[MODE_LSB +: 2] = osc_mode;
      zero_view[OUT_LSB +: 2] = out_div;
      one_view = 8'h00;
      one_view[SEL_BIT] = cpu_on_fast;
      one_view[EN_BIT] = fast_osc_enable;
      one_view[DBL_BIT] = doubler_enable;
      one_view[LOCK_BIT] = pll_lock_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic setup_phase;
   logic commit;
   logic hit_zero;
   logic hit_one;
   logic hit_word;
   logic wr_zero;
   logic wr_one;
   logic [7:0] wr_zero_data;
   logic [7:0] wr_one_data;
   apb_rsp_t next_apb_rsp;

   always_comb begin
      setup_phase = apb_req.psel && !apb_req.penable;
      // a write lands only at the edge where the master sees pready
      commit = apb_req.psel && apb_req.penable && apb_rsp.pready;
      hit_zero = (apb_req.paddr == ZERO_ADDR); // R13
      hit_one = (apb_req.paddr == ONE_ADDR); // R14
      // word view sits one index above register one and carries both bytes
      hit_word = (apb_req.paddr == FWORD_ADDR); // R13
      wr_zero = 1'b0;
      wr_one = 1'b0;
      wr_zero_data = apb_req.pwdata[7:0];
      wr_one_data = apb_req.pwdata[7:0];
      if (commit && apb_req.pwrite && !apb_rsp.pslverr) begin
         if (hit_zero) begin
            wr_zero = apb_req.pstrb[0];
         end
         if (hit_one) begin
            // byte-only register: its single byte sits in lane zero
            wr_one = apb_req.pstrb[0]; // R14
         end
         if (hit_word) begin
            wr_zero = apb_req.pstrb[0]; // R13
            wr_one = apb_req.pstrb[HI_LANE];
            wr_one_data = apb_req.pwdata[15:8];
         end
      end
   end

   always_comb begin
      next_apb_rsp = apb_rsp;
      // answer is registered at setup, so the access phase never waits
      if (setup_phase) begin
         next_apb_rsp.pready = 1'b1;
         // unmapped addresses answer with an error and read as zero
         next_apb_rsp.pslverr = !(hit_zero || hit_one || hit_word);
         next_apb_rsp.prdata = 32'h0000_0000;
         if (!apb_req.pwrite) begin
            if (hit_zero) begin
               next_apb_rsp.prdata[7:0] = zero_view; // R18
            end
            if (hit_one) begin
               next_apb_rsp.prdata[7:0] = one_view; // R18
            end
            if (hit_word) begin
               next_apb_rsp.prdata[15:0] = {one_view, zero_view}; // R13
            end
         end
      end else begin
         next_apb_rsp.pready = 1'b0;
         next_apb_rsp.pslverr = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp <= next_apb_rsp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register update

   always_comb begin
      next_fast_div = fast_div;
      next_out_div = out_div;
      next_osc_mode = osc_mode;
      next_fast_osc_enable = fast_osc_enable;
      next_cpu_on_fast = cpu_on_fast;
      next_doubler_enable = doubler_enable;
      if (wr_zero) begin
         next_fast_div = div_code_t'(wr_zero_data[DIV_LSB +: 2]); // R2
         next_out_div = div_code_t'(wr_zero_data[OUT_LSB +: 2]); // R7
         // the mode cannot move under a running oscillator
         if (!fast_osc_enable) begin
            next_osc_mode = osc_mode_t'(wr_zero_data[MODE_LSB +: 2]); // R5 R4
         end
      end
      if (wr_one) begin
         next_fast_osc_enable = wr_one_data[EN_BIT]; // R10
         next_doubler_enable = wr_one_data[DBL_BIT]; // R11
         next_cpu_on_fast = wr_one_data[SEL_BIT]; // R8
      end
      // select bit pinned to slow while the fast oscillator is off
      if (!next_fast_osc_enable) begin
         next_cpu_on_fast = 1'b0; // R9
      end
      // lock needs PLL mode, oscillator on and in-range frequency
      next_pll_lock_flag = pll_in_range && fast_osc_enable
         && (osc_mode == MODE_PLL); // R12
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fast_div <= div_code_t'(ZERO_RESET[DIV_LSB +: 2]); // R1 R2
         out_div <= div_code_t'(ZERO_RESET[OUT_LSB +: 2]); // R7
         osc_mode <= osc_mode_t'(ZERO_RESET[MODE_LSB +: 2]); // R1 R4
         fast_osc_enable <= ONE_RESET[EN_BIT]; // R10
         cpu_on_fast <= ONE_RESET[SEL_BIT]; // R1 R8
         doubler_enable <= ONE_RESET[DBL_BIT]; // R11
         pll_lock_flag <= ONE_RESET[LOCK_BIT];
      end else begin
         fast_div <= next_fast_div;
         out_div <= next_out_div;
         osc_mode <= next_osc_mode;
         fast_osc_enable <= next_fast_osc_enable;
         cpu_on_fast <= next_cpu_on_fast;
         doubler_enable <= next_doubler_enable;
         pll_lock_flag <= next_pll_lock_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // oscillator start-up

   start_state_t state;
   start_state_t next_state;
   logic [12:0] pulses;
   logic [12:0] next_pulses;
   logic [12:0] start_limit;
   logic next_valid;

   always_comb begin
      unique case (osc_mode)
         MODE_RC: start_limit = RC_START_COUNT; // R15
         MODE_XTAL: start_limit = XTAL_START_COUNT; // R16
         MODE_PLL: start_limit = PLL_START_COUNT; // R17
         MODE_EXT: start_limit = EXT_START_COUNT;
      endcase
      next_state = state;
      next_pulses = pulses;
      unique case (state)
         ST_OFF: begin
            // every enable restarts the count from zero
            next_pulses = 13'h0000;
            if (fast_osc_enable) begin
               next_state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (!fast_osc_enable) begin
               next_state = ST_OFF;
            end else if (osc_tick) begin
               next_pulses = pulses + 13'h0001;
               if (pulses + 13'h0001 >= start_limit) begin
                  next_state = ST_RUN; // R15 R16 R17
               end
            end
         end
         ST_RUN: begin
            if (!fast_osc_enable) begin
               next_state = ST_OFF;
            end
         end
         // the spare state code drops back to OFF
         default: begin
            next_state = ST_OFF;
         end
      endcase
      next_valid = (next_state == ST_RUN);
   end

   // the oscillator already runs when reset ends, so start in RUN
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN; // R1
         pulses <= 13'h0000;
         oscillator_clock_valid <= 1'b1;
      end else begin
         state <= next_state;
         pulses <= next_pulses;
         oscillator_clock_valid <= next_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dividers

   div_code_t eff_fast_div;
   div_code_t div_codes [2];
   logic div_ticks [2];

   always_comb begin
      eff_fast_div = fast_div;
      // undivided PLL output exceeds the fast clock limit, halve it
      if (osc_mode == MODE_PLL && fast_div == DIV_1) begin
         eff_fast_div = DIV_2; // R3
      end
      div_codes[0] = eff_fast_div; // R2
      div_codes[1] = out_div; // R7
   end

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : gen_div
         osc_divider u_div (
            .clk(clk_sys),
            .rst_n(rst_n),
            .tick_in(osc_tick),
            .run(oscillator_clock_valid),
            .code(div_codes[ch]),
            .tick_out(div_ticks[ch])
         );
      end
   endgenerate

   always_comb begin
      fast_clock_tick = div_ticks[0];
      port_output_clock_tick = div_ticks[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock routing

   logic next_cpu_tick;
   logic next_double_tick;

   always_comb begin
      // fast selected before start-up ends stalls the CPU, no fallback
      next_cpu_tick = cpu_on_fast ? fast_clock_tick : slow_tick; // R8
      // the doubled source keeps running, only its output is gated
      next_double_tick = doubler_enable && slow_double_tick; // R11
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clock_tick <= 1'b0;
         doubled_slow_clock_tick <= 1'b0;
      end else begin
         cpu_clock_tick <= next_cpu_tick;
         doubled_slow_clock_tick <= next_double_tick;
      end
   end

endmodule
`default_nettype wire

// ### testbench/clock_select_asserts.sv
// Purpose: port-level checks of the clock select block
// Assumes: one clock domain, rstn asynchronous active low
// Notes: tick relations are one registered cycle deep
`timescale 1ns/1ps
`default_nettype none
module clock_select_asserts
   import clock_select_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire apb_req_t apb_req,
   input wire apb_rsp_t apb_rsp,
   input wire logic osc_tick,
   input wire logic slow_tick,
   input wire logic slow_double_tick,
   input wire logic pll_in_range,
   input wire logic fast_osc_enable,
   input wire osc_mode_t osc_mode,
   input wire logic oscillator_clock_valid,
   input wire logic fast_clock_tick,
   input wire logic port_output_clock_tick,
   input wire logic cpu_clock_tick,
   input wire logic cpu_on_fast,
   input wire logic doubler_enable,
   input wire logic doubled_slow_clock_tick,
   input wire logic pll_lock_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   sel_forced_a: assert property (!fast_osc_enable |-> !cpu_on_fast)
      else $error("select set while oscillator off");
   mode_hold_a: assert property (fast_osc_enable && $past(fast_osc_enable) |-> $stable(osc_mode))
      else $error("mode changed while oscillator on");
   lock_flag_a: assert property (pll_lock_flag ==
      $past(pll_in_range && fast_osc_enable && osc_mode == MODE_PLL))
      else $error("lock flag wrong");
   dbl_gate_a: assert property (doubled_slow_clock_tick ==
      $past(doubler_enable && slow_double_tick))
      else $error("doubled tick wrong");
   cpu_route_a: assert property (cpu_clock_tick |->
      $past(cpu_on_fast ? fast_clock_tick : slow_tick))
      else $error("cpu tick from wrong source");
   tick_valid_a: assert property (fast_clock_tick || port_output_clock_tick |->
      $past(osc_tick && oscillator_clock_valid))
      else $error("tick without valid oscillator");
   stop_osc_a: assert property ($fell(fast_osc_enable) |-> ##[0:2] !oscillator_clock_valid)
      else $error("valid stays after disable");
   ready_once_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("error without ready");
endmodule
bind clock_select_and_divide clock_select_asserts u_chk (.clk_sys, .rstn, .apb_req, .apb_rsp,
   .osc_tick, .slow_tick, .slow_double_tick, .pll_in_range, .fast_osc_enable, .osc_mode,
   .oscillator_clock_valid, .fast_clock_tick, .port_output_clock_tick, .cpu_clock_tick,
   .cpu_on_fast, .doubler_enable, .doubled_slow_clock_tick, .pll_lock_flag);
`default_nettype wire

// ### testbench/clock_select_and_divide_tb.sv
// Purpose: self-checking bench of the clock select block
// Assumes: oscillator tick every 2 cycles, slow 16, doubled slow 8
// Notes: tick counts taken over 64-cycle windows at the falling edge
`timescale 1ns/1ps
`default_nettype none
module clock_select_and_divide_tb
   import clock_select_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic osc_tick = 1'b0;
   logic slow_tick = 1'b0;
   logic slow_double_tick = 1'b0;
   logic pll_in_range = 1'b0;
   logic en, valid, ft, pt, ct, onf, dbe, dt, lk;
   osc_mode_t md;
   logic [31:0] cyc = 32'h0;
   logic [31:0] rd;
   logic err;
   int fail_count = 0;
   int compares = 0;
   int n_osc = 0, n_f = 0, n_p = 0, n_c = 0, n_d = 0;
   int f, p, c, d;
   clock_select_and_divide DUT (.clk_sys(clk_sys), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
      .osc_tick(osc_tick), .slow_tick(slow_tick), .slow_double_tick(slow_double_tick),
      .pll_in_range(pll_in_range), .fast_osc_enable(en), .osc_mode(md),
      .oscillator_clock_valid(valid), .fast_clock_tick(ft), .port_output_clock_tick(pt),
      .cpu_clock_tick(ct), .cpu_on_fast(onf), .doubler_enable(dbe),
      .doubled_slow_clock_tick(dt), .pll_lock_flag(lk));
   ////////////////////////////////////////////////////////////////
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 32'h1;
      osc_tick <= cyc[0];
      slow_double_tick <= (cyc[2:0] == 3'h7);
      slow_tick <= (cyc[3:0] == 4'hF);
      if (cyc == 32'h0000_EA60) begin
         fail_count++;
         stop_test();
      end
   end
   // non-blocking so snapshots at the same edge see a consistent count
   always @(negedge clk_sys) begin
      n_osc <= n_osc + int'(osc_tick);
      n_f <= n_f + int'(ft);
      n_p <= n_p + int'(pt);
      n_c <= n_c + int'(ct);
      n_d <= n_d + int'(dt);
   end
   ////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // request held until ready is seen high at a rising edge, answer taken there
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:dat, pstrb:4'h3};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      @(posedge clk_sys);
      while (rsp.pready !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      chkn(n, 0, 49);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic measure();
      int f0, p0, c0, d0;
      repeat (16) @(negedge clk_sys);
      f0 = n_f;
      p0 = n_p;
      c0 = n_c;
      d0 = n_d;
      repeat (64) @(negedge clk_sys);
      f = n_f - f0;
      p = n_p - p0;
      c = n_c - c0;
      d = n_d - d0;
   endtask
   task automatic start_run(input logic [1:0] m, input int need);
      int o0, n;
      apb(1'b1, ONE_ADDR, 32'h0);
      apb(1'b1, ZERO_ADDR, {24'h0, 2'h0, 2'h3, m, 2'h3});
      rdchk(ZERO_ADDR, {24'h0, 2'h0, 2'h3, m, 2'h3});
      apb(1'b1, ONE_ADDR, 32'h3);
      o0 = n_osc;
      n = 0;
      while (valid !== 1'b1 && n < 20000) begin
         @(negedge clk_sys);
         n++;
      end
      chkn(n_osc - o0, need - 1, need + 1);
      chk({30'h0, md}, {30'h0, m});
      apb(1'b1, ZERO_ADDR, {24'h0, 2'h3, 2'h3, ~m, 2'h3});
      rdchk(ZERO_ADDR, {24'h0, 2'h0, 2'h3, m, 2'h3});
      chk({30'h0, md}, {30'h0, m});
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdchk(ZERO_ADDR, 32'h33);
      rdchk(ONE_ADDR, 32'h03);
      chk({28'h0, en, onf, dbe, lk}, 32'h0000_000C);
      measure();
      chkn(f, 4, 4);
      chkn(c, 4, 4);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, ZERO_ADDR, {24'h0, 2'(3 - k), 2'h0, 2'(k)});
         measure();
         chkn(f, 32 >> k, 32 >> k);
         chkn(p, 32 >> (3 - k), 32 >> (3 - k));
         chkn(c, 32 >> k, 32 >> k);
      end
      apb(1'b1, ONE_ADDR, 32'h0);
      rdchk(ONE_ADDR, 32'h0);
      chk({31'h0, onf}, 32'h0);
      chk({31'h0, en}, 32'h0);
      measure();
      chkn(c, 4, 4);
      chkn(f, 0, 0);
      apb(1'b1, ONE_ADDR, 32'h1);
      rdchk(ONE_ADDR, 32'h0);
      start_run(MODE_RC, 128);
      start_run(MODE_XTAL, 4096);
      start_run(MODE_EXT, 1);
      start_run(MODE_PLL, 4096);
      apb(1'b1, ZERO_ADDR, 32'h08);
      measure();
      chkn(f, 16, 16);
      chkn(p, 32, 32);
      pll_in_range <= 1'b1;
      rdchk(ONE_ADDR, 32'h83);
      chk({31'h0, lk}, 32'h1);
      pll_in_range <= 1'b0;
      apb(1'b1, ONE_ADDR, 32'h83);
      rdchk(ONE_ADDR, 32'h03);
      chk({31'h0, lk}, 32'h0);
      apb(1'b1, ONE_ADDR, 32'h7F);
      rdchk(ONE_ADDR, 32'h07);
      chk({31'h0, dbe}, 32'h1);
      measure();
      chkn(d, 8, 8);
      apb(1'b1, ONE_ADDR, 32'h03);
      measure();
      chkn(d, 0, 0);
      rdchk(FWORD_ADDR, 32'h0308);
      apb(1'b1, FWORD_ADDR, 32'h0706);
      rdchk(ZERO_ADDR, 32'h0A);
      rdchk(ONE_ADDR, 32'h07);
      apb(1'b0, 20'h00100, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
